// ---- ext_request_regs.vh ----
// Constants for the external request front end.
`ifndef EXT_REQUEST_REGS_VH
`define EXT_REQUEST_REGS_VH
`define EXT_NUM_INPUTS 8
`define EXT_NUM_IRQ 4
// Detection condition codes, two bits per input.
`define DET_LOW_LEVEL 2'h0
`define DET_HIGH_LEVEL 2'h1
`define DET_RISING_EDGE 2'h2
`define DET_FALLING_EDGE 2'h3
// Request numbers toward the CPU interrupt logic.
`define IRQ_NUM_A 8'h0F
`define IRQ_NUM_B 8'h14
`define IRQ_NUM_C 8'h18
`define IRQ_NUM_D 8'h1B
// Reset values.
`define FLAG_RESET 8'h00
`endif

// ---- ext_request_detect.v ----
// One external request channel: synchroniser and condition detector.
`timescale 1ns/1ps
`include "ext_request_regs.vh"
module ext_request_detect (
  input wire clk_sys, // machine clock
  input wire rst_sync_n, // synchronised reset, active low
  input wire pin_in, // asynchronous request pin
  input wire [1:0] condition, // detection condition code
  input wire transfer_mode, // channel serves data transfer requests
  output reg hit // condition seen this cycle
);
  reg sync_a;
  reg sync_b;
  reg prev;
  // ****************************************
  // Synchroniser
  // ****************************************
  // two stage sync
  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end
  // ****************************************
  // Detector
  // ****************************************
  always @*
  begin
    case (condition)
      `DET_LOW_LEVEL: hit = ~sync_b;
      `DET_HIGH_LEVEL: hit = sync_b;
      `DET_RISING_EDGE: hit = ~transfer_mode & sync_b & ~prev;
      default: hit = ~transfer_mode & ~sync_b & prev;
    endcase
  end
endmodule // ext_request_detect

// ---- ext_request_front.v ----
// External interrupt and data transfer request front end, eight inputs.
// Functional notes
// - Eight request inputs each select their own detection condition.
// - As plain interrupts, inputs detect high, low, rising or falling.
// - In transfer use only high or low level detection is honoured.
// - Eight inputs feed four request numbers 15, 20, 24 and 27.
// - A per-input enable gates that input's request to the CPU.
// - Each detected condition sets a readable per-input flag.
// - With the transfer service disabled a request is a CPU interrupt.
// - With it enabled a request starts a transfer, then interrupts at the end of the count.
// - Requests leave through the common prioritised peripheral request path.
`timescale 1ns/1ps
`include "ext_request_regs.vh"
module ext_request_front (
  input wire clk_sys, // machine clock, 125 MHz
  input wire rst_n, // asynchronous reset, active low
  input wire [7:0] ext_request_pins, // external request pins
  input wire [15:0] detect_condition_select, // two bits per input
  input wire [7:0] ext_request_enable_mask, // per-input enable
  input wire [3:0] transfer_service_enable, // per request number
  input wire [7:0] flag_write_data, // value written to the flags
  input wire flag_write, // write strobe for the flags
  input wire [3:0] transfer_done, // transfer count finished, pulse
  output reg [7:0] ext_request_flag_reg, // latched request flags
  output reg [3:0] irq_request, // CPU interrupt request per number
  output reg [3:0] data_transfer_request, // transfer request per number
  output wire [31:0] irq_numbers // request numbers, four bytes
);
  reg rst_a;
  reg rst_sync_n;
  reg [3:0] end_pending;
  reg [3:0] next_end_pending;
  reg [3:0] next_irq;
  reg [3:0] next_transfer;
  reg [7:0] next_flag;
  reg [7:0] flag_keep;
  wire [7:0] hit;
  wire [3:0] group;
  wire [7:0] number_a;
  wire [7:0] number_b;
  wire [7:0] number_c;
  wire [7:0] number_d;
  integer i;
  integer j;

  // ****************************************
  // Helper functions
  // ****************************************
  // Folds the two enabled flags of one request number into one request.
  function pair_request;
    input [7:0] flags;
    input [7:0] enables;
    input integer number;
    begin
      pair_request = (flags[2*number] & enables[2*number]) |
        (flags[2*number+1] & enables[2*number+1]);
    end
  endfunction

  // Gives the flag bits that survive this cycle's software write.
  function [7:0] write_keep;
    input [7:0] data;
    input strobe;
    begin
      if (strobe)
        write_keep = data;
      else
        write_keep = 8'hFF;
    end
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_a <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_a <= 1'b1;
      rst_sync_n <= rst_a;
    end
  end
  // ****************************************
  // Channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `EXT_NUM_INPUTS; g = g + 1)
    begin : chan
      ext_request_detect u_det (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .pin_in(ext_request_pins[g]),
        .condition(detect_condition_select[2*g+1:2*g]),
        .transfer_mode(transfer_service_enable[g/2]),
        .hit(hit[g])
      );
    end
  endgenerate

  // ****************************************
  // Flags
  // ****************************************
  // A level condition that is still present sets its flag on the same edge as the clear.
  // A clear therefore only sticks once the condition has gone away.
  always @*
  begin
    flag_keep = write_keep(flag_write_data, flag_write);
    next_flag = ext_request_flag_reg & flag_keep;
    next_flag = next_flag | hit;
  end

  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ext_request_flag_reg <= `FLAG_RESET;
    else
      ext_request_flag_reg <= next_flag;
  end

  // ****************************************
  // Request grouping
  // ****************************************
  // enable gates output
  assign group[0] = pair_request(ext_request_flag_reg, ext_request_enable_mask, 0);
  assign group[1] = pair_request(ext_request_flag_reg, ext_request_enable_mask, 1);
  assign group[2] = pair_request(ext_request_flag_reg, ext_request_enable_mask, 2);
  assign group[3] = pair_request(ext_request_flag_reg, ext_request_enable_mask, 3);

  // ****************************************
  // End of transfer count
  // ****************************************
  // Remembers per request number that the transfer service finished its count.
  // Software acknowledges the final interrupt by turning the service off.
  always @*
  begin
    next_end_pending = end_pending;
    for (i = 0; i < `EXT_NUM_IRQ; i = i + 1)
    begin
      if (!transfer_service_enable[i])
        next_end_pending[i] = 1'b0;
      else if (transfer_done[i])
        next_end_pending[i] = 1'b1;
    end
  end

  // ****************************************
  // Request routing
  // ****************************************
  // While the service is on, the transfer request stands until the count ends.
  // The final interrupt then stands until software turns the service off.
  always @*
  begin
    next_irq = 4'h0;
    next_transfer = 4'h0;
    for (j = 0; j < `EXT_NUM_IRQ; j = j + 1)
    begin
      if (transfer_service_enable[j])
      begin
        next_transfer[j] = group[j] & ~end_pending[j];
        next_irq[j] = end_pending[j];
      end
      else
      begin
        next_irq[j] = group[j];
      end
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      end_pending <= 4'h0;
      irq_request <= 4'h0;
      data_transfer_request <= 4'h0;
    end
    else
    begin
      end_pending <= next_end_pending;
      irq_request <= next_irq;
      data_transfer_request <= next_transfer;
    end
  end

  // ****************************************
  // Request numbers
  // ****************************************
  // four request numbers
  assign number_a = `IRQ_NUM_A;
  assign number_b = `IRQ_NUM_B;
  assign number_c = `IRQ_NUM_C;
  assign number_d = `IRQ_NUM_D;
  assign irq_numbers = {number_d, number_c, number_b, number_a};
endmodule // ext_request_front

// ---- ext_peripheral_model.sv ----
// Model of the peripherals that drive the request pins.
`timescale 1ns/1ps
module ext_peripheral_model (
  input wire clk_sys, // machine clock
  input wire [7:0] want, // level each device asks for
  input wire [7:0] lag, // devices that answer a cycle late
  output reg [7:0] pins = 0 // request pins
);
  reg [7:0] d = 0;
  always @(posedge clk_sys)
  begin
    d <= want;
    pins <= #3 (want & ~lag) | (d & lag);
  end
endmodule // ext_peripheral_model

// ---- ext_request_props.sv ----
// Checker bound to the external request front end.
`timescale 1ns/1ps
module ext_request_props (
  input wire clk_sys, rst_n, flag_write,
  input wire [7:0] ext_request_pins, ext_request_enable_mask, flag_write_data,
  input wire [7:0] ext_request_flag_reg,
  input wire [15:0] detect_condition_select,
  input wire [3:0] transfer_service_enable, transfer_done,
  input wire [3:0] irq_request, data_transfer_request,
  input wire [31:0] irq_numbers
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [1:0] c = detect_condition_select[1:0];
  wire s = transfer_service_enable[0];
  wire f = ext_request_flag_reg[0];
  wire p = ext_request_pins[0];
  wire m = ext_request_enable_mask[0];
  wire q = |ext_request_enable_mask[1:0];
  sequence s_rise;
    (!p && c == 2'h2 && !s) ##1 (p && c == 2'h2 && !s && !flag_write)[*6];
  endsequence
  sequence s_svc;
    !s ##1 (s && f && m && !transfer_done[0])[*3];
  endsequence
  a_number_map: assert property (irq_numbers == 32'h1B18140F)
    else $error("bad numbers");
  a_level_high: assert property ((p && c == 2'h1)[*6] |=> f)
    else $error("level missed");
  a_rise_seen: assert property (s_rise |=> f)
    else $error("edge missed");
  a_edge_refused: assert property ((s && c[1])[*5] ##0 !f |=> !f)
    else $error("edge taken");
  a_flag_hold: assert property (f && !(flag_write && !flag_write_data[0]) |=> f)
    else $error("flag lost");
  a_mask_gate: assert property ((!q && !s)[*2] |=> !irq_request[0])
    else $error("masked request");
  a_irq_path: assert property ((f && m && !s)[*2] |=> irq_request[0])
    else $error("no request");
  a_svc_path: assert property (s_svc |=> data_transfer_request[0])
    else $error("no transfer");
  sequence s_count_end;
    (s && transfer_done[0]) ##1 s;
  endsequence
  a_end_irq: assert property (s_count_end |=> irq_request[0])
    else $error("no end request");
endmodule // ext_request_props
bind ext_request_front ext_request_props p_u (.*);

// ---- tb.sv ----
// Self-checking bench for the external request front end.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, rst_n = 0, fw = 0;
  logic [7:0] want = 0, lag = 0, mask = 0, fwd = 0;
  logic [15:0] dcs = 0;
  logic [3:0] tse = 0, done = 0;
  logic [1:0] c;
  wire [7:0] pins, fl;
  wire [3:0] irq, dtr;
  wire [31:0] nums;
  int err_total = 0, checks_done = 0;
  ext_peripheral_model per_u (.clk_sys(clk_sys), .want(want), .lag(lag), .pins(pins));
  ext_request_front dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ext_request_pins(pins),
    .detect_condition_select(dcs), .ext_request_enable_mask(mask),
    .transfer_service_enable(tse), .flag_write_data(fwd), .flag_write(fw),
    .transfer_done(done), .ext_request_flag_reg(fl), .irq_request(irq),
    .data_transfer_request(dtr), .irq_numbers(nums));
  initial forever #4 clk_sys = ~clk_sys;
  function automatic [3:0] pr(input [7:0] v);
    pr = {|v[7:6], |v[5:4], |v[3:2], |v[1:0]};
  endfunction
  function automatic [7:0] act(input [1:0] k);
    act = (k == 2'h1 || k == 2'h2) ? 8'hFF : 8'h00;
  endfunction
  task chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input [7:0] d);
    tick(1); fwd <= d; fw <= 1; tick(1); fw <= 0;
  endtask
  // Clears all flags with the condition absent, then makes it present.
  task arm(input [1:0] k);
    dcs <= {8{k}}; want <= ~act(k); tick(6); wr(8'h00); tick(1); want <= act(k); tick(8);
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(71279));
    tick(16); rst_n <= 1; tick(4);
    chk("numbers", nums, 32'h1B18140F);
    for (int k = 0; k < 4; k++)
    begin
      c = k; mask <= $urandom; lag <= $urandom; arm(c);
      chk("flags", fl, 8'hFF);
      chk("irq", irq, pr(mask));
      wr(8'hFF); tick(2);
      chk("kept", fl, 8'hFF);
      want <= ~act(c); tick(6); wr(8'h00); tick(2);
      chk("cleared", fl, 8'h00);
    end
    c = $urandom_range(1, 0); tse <= 4'hF; mask <= 8'hFF; arm(c);
    chk("transfer", {irq, dtr}, 8'h0F);
    done <= 4'hF; tick(1); done <= 4'h0; tick(3);
    chk("end irq", {irq, dtr}, 8'hF0);
    arm(2'h2);
    chk("edge off", fl, 8'h00);
    repeat (300)
    begin
      tick(1); want <= $urandom; dcs <= $urandom; mask <= $urandom; tse <= $urandom;
      done <= $urandom; fwd <= $urandom; fw <= $urandom;
    end
    conclude;
  end
endmodule // tb
